// ===== src/tiu_top.v
// Two prescaled down timers and six-source vectored interrupt controller
`timescale 1ns/1ps
`include "tiu_defines.vh"
module tiu_top #(
    parameter NREQ = 6
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        port3_input_one,
    input  wire        port3_input_two,
    input  wire        port3_input_three,
    input  wire        irq_take,
    output reg         irq_pending_reg,
    output reg  [3:0]  irq_vector_addr_reg,
    output reg  [2:0]  irq_source_reg
);
    // Byte address = 4 * printed register number (printed numbers not aligned)
    function [7:0] ridx;
        input [9:0] a;
        ridx = a[9:2];
    endfunction
    // Priority grouping: one of six orders over the three pairs
    function [2:0] pick;
        input [5:0] p;
        input [7:0] pr;
        reg [2:0] g0, g1, g2;
        reg       s0, s1, s2;
        reg [1:0] grp;
        reg [2:0] fa, fb, fc;
        reg [5:0] kk;
        reg [1:0] k;
        begin
            pick = 3'b111;
            s0 = pr[1];
            s1 = pr[2];
            s2 = pr[5];
            g0 = s0 ? 3'd1 : 3'd0;
            g1 = s1 ? 3'd3 : 3'd2;
            g2 = s2 ? 3'd5 : 3'd4;
            fa = 3'd0;
            fb = 3'd0;
            fc = 3'd0;
            grp = 2'd0;
            kk = 6'd0;
            k = 2'd0;
            case ({pr[4], pr[3], pr[0]})
                3'b001: begin fa = 3'd1; fb = 3'd0; fc = 3'd2; end
                3'b010: begin fa = 3'd0; fb = 3'd2; fc = 3'd1; end
                3'b011: begin fa = 3'd0; fb = 3'd1; fc = 3'd2; end
                3'b100: begin fa = 3'd2; fb = 3'd1; fc = 3'd0; end
                3'b101: begin fa = 3'd2; fb = 3'd0; fc = 3'd1; end
                3'b110: begin fa = 3'd1; fb = 3'd2; fc = 3'd0; end
                default: begin fa = 3'd0; fb = 3'd1; fc = 3'd2; end
            endcase
            for (kk = 6'd0; kk < 6'd6; kk = kk + 6'd1) begin
                k = kk[1:0];
                if (pick == 3'b111) begin
                    grp = (kk < 6'd2) ? fa[1:0] :
                          (kk < 6'd4) ? fb[1:0] : fc[1:0];
                    g0 = (kk[0] ^ s0) ? 3'd0 : 3'd1;
                    g1 = (kk[0] ^ s1) ? 3'd2 : 3'd3;
                    g2 = (kk[0] ^ s2) ? 3'd4 : 3'd5;
                    case (grp)
                        2'd0: if (p[g0]) pick = g0;
                        2'd1: if (p[g1]) pick = g1;
                        default: if (p[g2]) pick = g2;
                    endcase
                end
            end
            if (k == 2'd3) pick = pick;
        end
    endfunction

    reg [2:0] sy_a, sy_b;
    reg [2:0] pin_prev;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy_a     <= 3'b111;
            sy_b     <= 3'b111;
            pin_prev <= 3'b111;
        end else if (clk_en) begin
            sy_a     <= {port3_input_three, port3_input_two, port3_input_one};
            sy_b     <= sy_a;
            pin_prev <= sy_b;
        end
    end
    wire an1 = sy_b[0];
    wire an2 = sy_b[1];
    wire rf  = sy_b[2];

    reg  [7:0] tmode_reg, imask_reg, iprio_reg, cmpen_reg;
    reg  [5:0] ipend_reg;
    reg  [7:0] t0_init_reg, t1_init_reg, t0_cnt_reg, t1_cnt_reg;
    reg  [7:0] t0_pre_reg, t1_pre_reg;
    reg  [5:0] p0_cnt_reg, p1_cnt_reg;
    reg        t0_run_reg, t1_run_reg, trig_seen_reg;
    reg  [1:0] div4_reg;

    // AXI write path: accept address and data in either order
    reg        aw_hold, w_hold;
    reg  [9:0] aw_addr;
    reg  [31:0] w_data;
    reg  [3:0] w_strb;
    wire       wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    wire [7:0] wr_idx  = ridx(aw_addr);
    wire       wr_ok   = w_strb[0];
    wire [7:0] wd      = w_data[7:0];
    wire       wr_hit  = (wr_idx == `TIU_ADDR_TMODE) ||
                         (wr_idx == `TIU_ADDR_T1CNT) ||
                         (wr_idx == `TIU_ADDR_T1PRE) ||
                         (wr_idx == `TIU_ADDR_T0CNT) ||
                         (wr_idx == `TIU_ADDR_T0PRE) ||
                         (wr_idx == `TIU_ADDR_IPRIO) ||
                         (wr_idx == `TIU_ADDR_IPEND) ||
                         (wr_idx == `TIU_ADDR_IMASK) ||
                         (wr_idx == `TIU_ADDR_ICTRL) ||
                         (wr_idx == `TIU_ADDR_CMPEN);
    wire wsel_tm = wr_fire && wr_ok && wr_idx == `TIU_ADDR_TMODE;
    wire wsel_1c = wr_fire && wr_ok && wr_idx == `TIU_ADDR_T1CNT;
    wire wsel_1p = wr_fire && wr_ok && wr_idx == `TIU_ADDR_T1PRE;
    wire wsel_0c = wr_fire && wr_ok && wr_idx == `TIU_ADDR_T0CNT;
    wire wsel_0p = wr_fire && wr_ok && wr_idx == `TIU_ADDR_T0PRE;
    wire wsel_ip = wr_fire && wr_ok && wr_idx == `TIU_ADDR_IPEND;

    // Timer clock sources
    wire [1:0] ext_mode = tmode_reg[`TIU_TM_EXTHI:`TIU_TM_EXTLO];
    wire t1_ext_sel = !t1_pre_reg[`TIU_PRE_SRC];
    wire in_fall    = pin_prev[0] && !an1;
    wire int_tick   = (div4_reg == `TIU_T1_INT_DIV);
    reg  t1_tick;
    always @* begin
        t1_tick = 1'b0;
        if (!t1_ext_sel)
            t1_tick = int_tick;
        else case (ext_mode)
            `TIU_EXT_CLOCK: t1_tick = in_fall;
            `TIU_EXT_GATE:  t1_tick = int_tick && an1;
            default:        t1_tick = int_tick && trig_seen_reg;
        endcase
    end
    wire t0_tick = int_tick;
    wire trig_hit = t1_ext_sel && in_fall &&
                    (ext_mode == `TIU_EXT_RETRIG ||
                     (ext_mode == `TIU_EXT_TRIG && !trig_seen_reg));

    // Prescaler field 0 means 64 because 6-bit count wraps from zero to 63
    wire p0_end = t0_run_reg && t0_tick && p0_cnt_reg == 6'd1;
    wire p1_end = t1_run_reg && t1_tick && p1_cnt_reg == 6'd1;
    wire t0_eoc = p0_end && t0_cnt_reg == 8'h01;
    wire t1_eoc = p1_end && t1_cnt_reg == 8'h01;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div4_reg      <= 2'b00;
            t0_cnt_reg    <= 8'h00;
            t1_cnt_reg    <= 8'h00;
            t0_init_reg   <= 8'h00;
            t1_init_reg   <= 8'h00;
            t0_pre_reg    <= 8'h00;
            t1_pre_reg    <= 8'h00;
            p0_cnt_reg    <= 6'd0;
            p1_cnt_reg    <= 6'd0;
            t0_run_reg    <= 1'b0;
            t1_run_reg    <= 1'b0;
            trig_seen_reg <= 1'b0;
            tmode_reg     <= `TIU_TMODE_RST;
        end else if (clk_en) begin
            div4_reg <= div4_reg + 2'b01;
            if (wsel_0c) t0_init_reg <= wd;
            if (wsel_1c) t1_init_reg <= wd;
            if (wsel_0p) t0_pre_reg  <= wd;
            if (wsel_1p) t1_pre_reg  <= wd;
            // Load bits are strobes; run bits and bits 7:4 (input mode in 5:4) are kept
            if (wsel_tm) tmode_reg   <= {wd[7:4], wd[3], 1'b0, wd[1], 1'b0};
            // Timer 0
            if (wsel_tm && wd[`TIU_TM_LOAD0]) begin
                t0_cnt_reg <= t0_init_reg;
                p0_cnt_reg <= t0_pre_reg[7:2];
            end else if (p0_end) begin
                p0_cnt_reg <= t0_pre_reg[7:2];
                if (t0_cnt_reg == 8'h01) begin
                    t0_cnt_reg <= t0_pre_reg[`TIU_PRE_CONT] ?
                                  t0_init_reg : 8'h00;
                    if (!t0_pre_reg[`TIU_PRE_CONT]) t0_run_reg <= 1'b0;
                end else
                    t0_cnt_reg <= t0_cnt_reg - 8'h01;
            end else if (t0_run_reg && t0_tick)
                p0_cnt_reg <= p0_cnt_reg - 6'd1;
            if (wsel_tm) t0_run_reg <= wd[`TIU_TM_RUN0];
            // Timer 1
            if (trig_hit) begin
                trig_seen_reg <= 1'b1;
                t1_cnt_reg <= t1_init_reg;
                p1_cnt_reg <= t1_pre_reg[7:2];
            end else if (wsel_tm && wd[`TIU_TM_LOAD1]) begin
                t1_cnt_reg <= t1_init_reg;
                p1_cnt_reg <= t1_pre_reg[7:2];
                trig_seen_reg <= 1'b0;
            end else if (p1_end) begin
                p1_cnt_reg <= t1_pre_reg[7:2];
                if (t1_cnt_reg == 8'h01) begin
                    t1_cnt_reg <= t1_pre_reg[`TIU_PRE_CONT] ?
                                  t1_init_reg : 8'h00;
                    if (!t1_pre_reg[`TIU_PRE_CONT]) begin
                        t1_run_reg    <= 1'b0;
                        trig_seen_reg <= 1'b0;
                    end
                end else
                    t1_cnt_reg <= t1_cnt_reg - 8'h01;
            end else if (t1_run_reg && t1_tick)
                p1_cnt_reg <= p1_cnt_reg - 6'd1;
            if (wsel_tm) t1_run_reg <= wd[`TIU_TM_RUN1];
        end
    end

    // Edge sources; comparators gate the analog inputs
    wire [5:0] req_set;
    assign req_set[0] = cmpen_reg[1] && pin_prev[1] && !an2;
    assign req_set[1] = pin_prev[2] && !rf;
    assign req_set[2] = cmpen_reg[0] && pin_prev[0] && !an1;
    assign req_set[3] = cmpen_reg[1] && !pin_prev[1] && an2;
    assign req_set[4] = t0_eoc;
    assign req_set[5] = t1_eoc;

    wire [5:0] enabled = ipend_reg & imask_reg[5:0];
    wire       gl_en   = imask_reg[`TIU_IMASK_GLOBAL];
    wire [2:0] winner  = pick(enabled, iprio_reg);
    wire       grant   = irq_pending_reg && irq_take;
    reg  [5:0] clr_mask;
    integer    i;
    always @* begin
        clr_mask = 6'd0;
        for (i = 0; i < NREQ; i = i + 1)
            if (grant && irq_source_reg == i[2:0])
                clr_mask[i] = 1'b1;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ipend_reg <= 6'd0;
            imask_reg <= `TIU_IMASK_RST;
            iprio_reg <= `TIU_IPRIO_RST;
            cmpen_reg <= `TIU_CMPEN_RST;
            irq_pending_reg     <= 1'b0;
            irq_vector_addr_reg <= 4'h0;
            irq_source_reg      <= 3'd0;
        end else if (clk_en) begin
            // Set wins over software write and grant clear
            ipend_reg <= ((wsel_ip ? wd[5:0] : ipend_reg) & ~clr_mask)
                         | req_set;
            if (wr_fire && wr_ok && wr_idx == `TIU_ADDR_IMASK)
                imask_reg <= wd;
            if (wr_fire && wr_ok && wr_idx == `TIU_ADDR_IPRIO)
                iprio_reg <= {2'b00, wd[5:0]};
            if (wr_fire && wr_ok && wr_idx == `TIU_ADDR_CMPEN)
                cmpen_reg <= {6'd0, wd[1:0]};
            if (grant) begin
                irq_pending_reg <= 1'b0;
                imask_reg[`TIU_IMASK_GLOBAL] <= 1'b0;
            end else if (!irq_pending_reg && gl_en && |enabled) begin
                irq_pending_reg     <= 1'b1;
                irq_source_reg      <= winner;
                irq_vector_addr_reg <= {winner, 1'b0};
            end
        end
    end

    // AXI handshake and read mux
    reg [7:0] rd_val;
    reg       rd_hit;
    always @* begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        case (ridx(s_axi_araddr))
            `TIU_ADDR_TMODE: rd_val = tmode_reg;
            `TIU_ADDR_T1CNT: rd_val = t1_cnt_reg;
            `TIU_ADDR_T0CNT: rd_val = t0_cnt_reg;
            `TIU_ADDR_T1PRE: rd_val = 8'h00;
            `TIU_ADDR_T0PRE: rd_val = 8'h00;
            `TIU_ADDR_IPRIO: rd_val = iprio_reg;
            `TIU_ADDR_IPEND: rd_val = {2'b00, ipend_reg};
            `TIU_ADDR_IMASK: rd_val = imask_reg;
            `TIU_ADDR_ICTRL: rd_val = {irq_pending_reg, 3'b000,
                                       irq_vector_addr_reg};
            `TIU_ADDR_CMPEN: rd_val = cmpen_reg;
            default:         rd_hit = 1'b0;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= 10'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h0000_0000;
        end else if (clk_en) begin
            s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_val};
                s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== include/tiu_defines.vh
// Register indices, field positions and reset values, timer-interrupt unit
// Behaviour
// - Six request sources, each maskable, each in priority resolution.
// - Req 0,1,2 fall on analog two, ref, analog one; req 3 analog two rise.
// - Request n vector sits at program bytes 2n and 2n+1, twelve bytes.
// - Mask register has global enable plus one enable per request.
// - Pending requests resolved by encoder ordered through priority register.
// - Grant disables interrupts, saves PC and flags, branches to the vector.
// - Service address is the vector byte and the following byte.
// - Masked sources still set request flags; software may poll them.
// - Two 8-bit counters, each with its own 6-bit prescaler.
// - First timer internal clock only; second internal or external.
// - Prescalers divide by any integer 1 to 64.
// - Counter decrements per prescaler pulse; loaded value counts 1 to 256.
// - Prescaler and counter end of count raise request 4 or 5.
// - Software can start, stop, continue, or restart from initial value.
// - Single-pass stops at zero; continuous mode reloads and counts on.
// - Counters readable without disturbance; prescalers not readable.
// - Second timer clock is internal clock over four or port3 input one.
// - External input is clock, retrigger, non-retrigger trigger, or gate.
// - Comparator interrupts on both edges of second, falling of first.
`ifndef TIU_DEFINES_VH
`define TIU_DEFINES_VH
`define TIU_ADDR_TMODE    8'hF1
`define TIU_ADDR_T1CNT    8'hF2
`define TIU_ADDR_T1PRE    8'hF3
`define TIU_ADDR_T0CNT    8'hF4
`define TIU_ADDR_T0PRE    8'hF5
`define TIU_ADDR_IPRIO    8'hF8
`define TIU_ADDR_IPEND    8'hF9
`define TIU_ADDR_IMASK    8'hFA
`define TIU_ADDR_ICTRL    8'hFC
`define TIU_ADDR_IACK     8'hFD
`define TIU_ADDR_CMPEN    8'hFE
`define TIU_TM_LOAD0      0
`define TIU_TM_RUN0       1
`define TIU_TM_LOAD1      2
`define TIU_TM_RUN1       3
`define TIU_TM_EXTLO      4
`define TIU_TM_EXTHI      5
`define TIU_PRE_CONT      0
`define TIU_PRE_SRC       1
`define TIU_IMASK_GLOBAL  7
`define TIU_EXT_CLOCK     2'b00
`define TIU_EXT_GATE      2'b01
`define TIU_EXT_TRIG      2'b10
`define TIU_EXT_RETRIG    2'b11
`define TIU_T1_INT_DIV    2'b11
`define TIU_TMODE_RST     8'h00
`define TIU_IMASK_RST     8'h00
`define TIU_IPRIO_RST     8'h00
`define TIU_CMPEN_RST     8'h03
`endif

// ===== bench/tiu_top_sva.sv
// Port checks for the timer and interrupt unit
`timescale 1ns/1ps
module tiu_top_sva #(
    parameter NREQ = 6
) (
    input wire        clk,
    input wire        rst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        irq_take,
    input wire        irq_pending_reg,
    input wire [3:0]  irq_vector_addr_reg,
    input wire [2:0]  irq_source_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ar_ready_soon: assert property ($rose(s_axi_arvalid)
        |-> ##[1:2] s_axi_arready) else $error("arready late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("rvalid not one cycle after AR");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        |-> ##[1:4] s_axi_bvalid) else $error("no write response");
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_bresp_legal: assert property (s_axi_bvalid
        |-> s_axi_bresp != 2'b01 && s_axi_bresp != 2'b11)
        else $error("illegal write response");
    a_rdata_upper: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper data set");
    a_vector_pair: assert property (
        irq_pending_reg |-> irq_vector_addr_reg == {irq_source_reg, 1'b0})
        else $error("vector not twice the source");
    a_source_range: assert property (
        irq_pending_reg |-> irq_source_reg < NREQ) else $error("bad source");
    a_grant_clears: assert property (
        irq_take && irq_pending_reg |=> !irq_pending_reg [*2])
        else $error("offer stays after grant");
endmodule
bind tiu_top tiu_top_sva #(.NREQ(NREQ)) u_sva (
    .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_take(irq_take),
    .irq_pending_reg(irq_pending_reg),
    .irq_vector_addr_reg(irq_vector_addr_reg),
    .irq_source_reg(irq_source_reg));

// ===== bench/tiu_core_model.sv
// Processor core model that accepts offered interrupts
`timescale 1ns/1ps
module tiu_core_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [3:0] take_delay,
    input  wire       irq_pending_reg,
    input  wire [3:0] irq_vector_addr_reg,
    input  wire [2:0] irq_source_reg,
    output reg        irq_take,
    output reg  [2:0] took_src,
    output reg  [3:0] took_vec,
    output reg  [3:0] took_next,
    output reg  [7:0] took_count
);
    reg [3:0] wait_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_take   <= 1'b0;
            took_src   <= 3'h0;
            took_vec   <= 4'h0;
            took_next  <= 4'h0;
            took_count <= 8'h00;
            wait_reg   <= 4'h0;
        end else begin
            irq_take <= 1'b0;
            // Slow cores leave the offer standing for a while
            if (irq_pending_reg && !irq_take) begin
                if (wait_reg == take_delay) begin
                    irq_take   <= 1'b1;
                    took_src   <= irq_source_reg;
                    took_vec   <= irq_vector_addr_reg;
                    took_next  <= irq_vector_addr_reg + 4'h1;
                    took_count <= took_count + 8'h01;
                    wait_reg   <= 4'h0;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end else begin
                wait_reg <= 4'h0;
            end
        end
    end
endmodule

// ===== bench/tb_tiu_top.sv
// Self-checking bench for the timer and interrupt unit
`timescale 1ns/1ps
module tb_tiu_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic [9:0]  aw_a = 10'h000;
    logic        aw_v = 1'b0;
    logic [31:0] w_d = 32'h00000000;
    logic        w_v = 1'b0;
    logic        b_r = 1'b0;
    logic [9:0]  ar_a = 10'h000;
    logic        ar_v = 1'b0;
    logic        r_r = 1'b0;
    logic        p_one = 1'b1;
    logic        p_two = 1'b1;
    logic        p_three = 1'b1;
    logic [3:0]  take_delay = 4'h0;
    wire         aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq_take, pend;
    wire [1:0]   b_resp, r_resp;
    wire [31:0]  r_d;
    wire [3:0]   vec, took_vec, took_next;
    wire [2:0]   src, took_src;
    wire [7:0]   took_count;
    logic [7:0]  rd;
    logic [1:0]  rsp;
    int          n_mismatch = 0;
    int          check_count = 0;
    always #12.5 clk = ~clk;
    tiu_top u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
        .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_v), .s_axi_rready(r_r), .port3_input_one(p_one),
        .port3_input_two(p_two), .port3_input_three(p_three),
        .irq_take(irq_take), .irq_pending_reg(pend),
        .irq_vector_addr_reg(vec), .irq_source_reg(src));
    tiu_core_model u_core (.clk(clk), .rst_n(rst_n),
        .take_delay(take_delay), .irq_pending_reg(pend),
        .irq_vector_addr_reg(vec), .irq_source_reg(src),
        .irq_take(irq_take), .took_src(took_src), .took_vec(took_vec),
        .took_next(took_next), .took_count(took_count));
    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                          output logic [1:0] r);
        @(posedge clk);
        aw_a <= {a, 2'b00};
        w_d  <= {24'h000000, d};
        aw_v <= 1'b1;
        w_v  <= 1'b1;
        b_r  <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (!b_v);
        b_r <= 1'b0;
        r = b_resp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [7:0] d,
                          output logic [1:0] r);
        @(posedge clk);
        ar_a <= {a, 2'b00};
        ar_v <= 1'b1;
        r_r  <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_rdy) ar_v <= 1'b0;
        end while (!r_v);
        r_r <= 1'b0;
        d = r_d[7:0];
        r = r_resp;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] m, input logic [7:0] exp);
        axi_rd(a, rd, rsp);
        chk(what, {24'h000000, exp & m}, {24'h000000, rd & m});
    endtask
    // Pins change on the clock edge, then settle past the synchroniser
    task automatic pin(input int which, input logic v);
        @(posedge clk);
        case (which)
            1: p_one <= v;
            2: p_two <= v;
            default: p_three <= v;
        endcase
        idle(8);
    endtask
    task automatic grant(input int n, input int which, input logic v,
                         input int k);
        axi_wr(8'hF9, 8'h00, rsp);
        axi_wr(8'hFA, 8'h80 | (8'h01 << n), rsp);
        pin(which, v);
        idle(12);
        chk("granted source", n, {29'h0, took_src});
        chk("vector byte", 2 * n, {28'h0, took_vec});
        chk("vector next", 2 * n + 1, {28'h0, took_next});
        chk("grant count", k, {24'h0, took_count});
        rd_chk("mask after grant", 8'hFA, 8'hFF, 8'h01 << n);
        rd_chk("flag after grant", 8'hF9, 8'h01 << n, 8'h00);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("mode reset", 8'hF1, 8'hFF, 8'h00);
        rd_chk("priority reset", 8'hF8, 8'hFF, 8'h00);
        rd_chk("flags reset", 8'hF9, 8'hFF, 8'h00);
        rd_chk("mask reset", 8'hFA, 8'hFF, 8'h00);
        rd_chk("comparator reset", 8'hFE, 8'hFF, 8'h03);
        axi_rd(8'hF0, rd, rsp);
        chk("unmapped read", 32'h2, {30'h0, rsp});
        axi_wr(8'hF0, 8'h55, rsp);
        chk("unmapped write", 32'h2, {30'h0, rsp});
        pin(2, 1'b0);
        pin(2, 1'b1);
        pin(3, 1'b0);
        pin(1, 1'b0);
        rd_chk("polled flags", 8'hF9, 8'hFF, 8'h0F);
        idle(40);
        rd_chk("flags held", 8'hF9, 8'hFF, 8'h0F);
        pin(3, 1'b1);
        pin(1, 1'b1);
        axi_wr(8'hF9, 8'h00, rsp);
        rd_chk("flags cleared", 8'hF9, 8'hFF, 8'h00);
        grant(0, 2, 1'b0, 1);
        grant(3, 2, 1'b1, 2);
        take_delay <= 4'h6;
        grant(1, 3, 1'b0, 3);
        pin(3, 1'b1);
        grant(2, 1, 1'b0, 4);
        pin(1, 1'b1);
        axi_wr(8'hF8, 8'h01, rsp);
        axi_wr(8'hF9, 8'h05, rsp);
        axi_wr(8'hFA, 8'h85, rsp);
        idle(20);
        chk("priority winner", 2, {29'h0, took_src});
        axi_wr(8'hFA, 8'h00, rsp);
        axi_wr(8'hF9, 8'h00, rsp);
        axi_wr(8'hF5, 8'h04, rsp);
        axi_wr(8'hF4, 8'h03, rsp);
        axi_wr(8'hF1, 8'h03, rsp);
        idle(80);
        rd_chk("first timer flag", 8'hF9, 8'h10, 8'h10);
        rd_chk("single pass end", 8'hF4, 8'hFF, 8'h00);
        axi_wr(8'hF5, 8'h05, rsp);
        axi_wr(8'hF4, 8'h02, rsp);
        axi_wr(8'hF1, 8'h03, rsp);
        idle(60);
        axi_wr(8'hF9, 8'h00, rsp);
        idle(60);
        rd_chk("reload flag", 8'hF9, 8'h10, 8'h10);
        axi_wr(8'hF1, 8'h00, rsp);
        axi_wr(8'hF4, 8'hC8, rsp);
        axi_wr(8'hF1, 8'h01, rsp);
        rd_chk("loaded count", 8'hF4, 8'hFF, 8'hC8);
        idle(300);
        rd_chk("stopped count", 8'hF4, 8'hFF, 8'hC8);
        axi_wr(8'hF9, 8'h00, rsp);
        axi_wr(8'hF3, 8'h04, rsp);
        axi_wr(8'hF2, 8'h02, rsp);
        axi_wr(8'hF1, 8'h0C, rsp);
        idle(60);
        rd_chk("no external clock", 8'hF9, 8'h20, 8'h00);
        repeat (4) begin
            pin(1, 1'b0);
            pin(1, 1'b1);
        end
        rd_chk("external end", 8'hF9, 8'h20, 8'h20);
        axi_wr(8'hF3, 8'h06, rsp);
        axi_wr(8'hF2, 8'h02, rsp);
        axi_wr(8'hF9, 8'h00, rsp);
        axi_wr(8'hF1, 8'h0C, rsp);
        idle(60);
        rd_chk("internal end", 8'hF9, 8'h20, 8'h20);
        axi_wr(8'hF3, 8'h04, rsp);
        pin(1, 1'b0);
        axi_wr(8'hF9, 8'h00, rsp);
        axi_wr(8'hF1, 8'h1C, rsp);
        idle(60);
        rd_chk("gate closed", 8'hF9, 8'h20, 8'h00);
        pin(1, 1'b1);
        idle(20);
        rd_chk("gate open", 8'hF9, 8'h20, 8'h20);
        axi_wr(8'hF9, 8'h00, rsp);
        axi_wr(8'hF1, 8'h2C, rsp);
        idle(60);
        rd_chk("no trigger", 8'hF9, 8'h20, 8'h00);
        pin(1, 1'b0);
        idle(20);
        rd_chk("triggered end", 8'hF9, 8'h20, 8'h20);
        conclude();
    end
endmodule
